// file: src/dsg_pkg.sv
// constants shared by the dual servo host glue
package dsg_pkg;
    localparam int ADDR_W = 10;
    localparam int BASE_W = 7;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFS_AX1_STATUS_CMD = 3'h0;
    localparam logic [2:0] OFS_AX1_DATA = 3'h1;
    localparam logic [2:0] OFS_AX2_STATUS_CMD = 3'h2;
    localparam logic [2:0] OFS_AX2_DATA = 3'h3;
    localparam logic [2:0] OFS_MOTOR_BRAKE = 3'h4;
    localparam logic [2:0] OFS_CHIP_HARD_RESET = 3'h5;
    localparam logic [2:0] OFS_IRQ_ENABLE_CAUSE = 3'h6;
    localparam logic [2:0] OFS_IRQ_ACK = 3'h7;
    localparam int BIT_CH1 = 0;
    localparam int BIT_CH2 = 1;
    localparam int BIT_LED = 0;
    localparam int BIT_IRQ_EN = 1;
    localparam int CAUSE_W = 4;
    localparam logic [1:0] RST_BRAKE = 2'h0;
    localparam logic [1:0] RST_CHIP_RESET = 2'h0;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_LED = 1'b0;
    localparam logic [CAUSE_W-1:0] RST_CAUSE = 4'h0;
    localparam logic RST_STROBE_B = 1'b1;
    localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] RST_ADDR = 10'h000;
endpackage : dsg_pkg

// file: src/dsg_strobe_edge.sv
// edge detector for an active-low bus strobe
`timescale 1ns/1ps
module dsg_strobe_edge
    import dsg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // strobe in
    input wire logic i_strobe_b,
    // edge pulses
    output logic o_start,
    output logic o_end
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = i_strobe_b;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_q <= RST_STROBE_B;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign o_start = prev_q & ~i_strobe_b;
    assign o_end = ~prev_q & i_strobe_b;
endmodule : dsg_strobe_edge

// file: src/dsg_irq_cause.sv
// sticky interrupt cause latch with read-to-clear
`timescale 1ns/1ps
module dsg_irq_cause
    import dsg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // raw sources and clear
    input wire logic [CAUSE_W-1:0] i_src,
    input wire logic i_clear,
    // latched causes
    output logic [CAUSE_W-1:0] o_cause
);
    logic [CAUSE_W-1:0] src_prev_q;
    logic [CAUSE_W-1:0] src_prev_d;
    logic [CAUSE_W-1:0] cause_q;
    logic [CAUSE_W-1:0] cause_d;
    logic [CAUSE_W-1:0] rise;

    always_comb begin
        rise = i_src & ~src_prev_q;
        src_prev_d = i_src;
        // a new event in the clearing cycle survives the clear
        cause_d = (i_clear ? RST_CAUSE : cause_q) | rise;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_prev_q <= RST_CAUSE;
            cause_q <= RST_CAUSE;
        end else begin
            src_prev_q <= src_prev_d;
            cause_q <= cause_d;
        end
    end

    assign o_cause = cause_q;
endmodule : dsg_irq_cause

// file: src/dsg_host_glue.sv
// host-side i/o decode and control glue of the dual servo card
`timescale 1ns/1ps
module dsg_host_glue
    import dsg_pkg::*;
(
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    // host i/o bus
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [BASE_W-1:0] I_BASE,
    input wire logic I_IOR_B,
    input wire logic I_IOW_B,
    input wire logic [DATA_W-1:0] I_DATA,
    output logic [DATA_W-1:0] O_DATA,
    output logic O_DATA_OE_B,
    // motion chip bus
    output logic [1:0] O_MC_CS_B,
    output logic O_MC_PS_B,
    output logic O_MC_RD_B,
    output logic O_MC_WR_B,
    output logic [DATA_W-1:0] O_MC_WDATA,
    input wire logic [DATA_W-1:0] I_MC1_RDATA,
    input wire logic [DATA_W-1:0] I_MC2_RDATA,
    // motion chip and drive events
    input wire logic [1:0] I_MC_IRQ,
    input wire logic [1:0] I_OVERHEAT,
    // card controls
    output logic [1:0] O_BRAKE,
    output logic [1:0] O_MC_RESET,
    output logic O_FAULT_LED,
    output logic O_IRQ
);
    function automatic logic port_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [BASE_W-1:0] base
    );
        port_hit = (addr[ADDR_W-1:3] == base);
    endfunction : port_hit

    logic rd_start;
    logic rd_end;
    logic wr_start;
    logic wr_end;
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] irq_src;
    logic ack_read;
    logic cur_hit;
    logic [2:0] cur_ofs;

    // address and data held one cycle so the closing strobe edge sees them
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] wdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [1:0] brake_q;
    logic [1:0] brake_d;
    logic [1:0] mc_reset_q;
    logic [1:0] mc_reset_d;
    logic irq_en_q;
    logic irq_en_d;
    logic led_q;
    logic led_d;
    logic irq_q;
    logic irq_d;
    logic wr_hit;

    dsg_strobe_edge u_rd_edge (
        .i_clk(I_REF_CLK),
        .i_rst_b(I_RST_B),
        .i_strobe_b(I_IOR_B),
        .o_start(rd_start),
        .o_end(rd_end)
    );

    dsg_strobe_edge u_wr_edge (
        .i_clk(I_REF_CLK),
        .i_rst_b(I_RST_B),
        .i_strobe_b(I_IOW_B),
        .o_start(wr_start),
        .o_end(wr_end)
    );

    assign irq_src = {I_MC_IRQ[BIT_CH2], I_MC_IRQ[BIT_CH1],
                      I_OVERHEAT[BIT_CH2], I_OVERHEAT[BIT_CH1]};

    // reads of the cause port never feed the clear; only offset 7 does
    assign ack_read = rd_end && port_hit(addr_q, I_BASE)
                      && addr_q[2:0] == OFS_IRQ_ACK;

    dsg_irq_cause u_cause (
        .i_clk(I_REF_CLK),
        .i_rst_b(I_RST_B),
        .i_src(irq_src),
        .i_clear(ack_read),
        .o_cause(cause)
    );

    assign cur_hit = port_hit(I_ADDR, I_BASE);
    assign cur_ofs = I_ADDR[2:0];
    assign wr_hit = wr_end && port_hit(addr_q, I_BASE);

    // host read data, refreshed every cycle of the strobe
    always_comb begin
        rdata_d = rdata_q;
        if (!I_IOR_B && cur_hit) begin
            if (cur_ofs == OFS_AX1_STATUS_CMD
                || cur_ofs == OFS_AX1_DATA) begin
                rdata_d = I_MC1_RDATA;
            end else if (cur_ofs == OFS_AX2_STATUS_CMD
                         || cur_ofs == OFS_AX2_DATA) begin
                rdata_d = I_MC2_RDATA;
            end else if (cur_ofs == OFS_IRQ_ENABLE_CAUSE) begin
                // live levels let software poll overheat without an irq
                rdata_d = {{(DATA_W-CAUSE_W){1'b0}},
                           cause | irq_src};
            end else begin
                rdata_d = RST_DATA; // offsets 4, 5, 7 return nothing
            end
        end
    end

    always_comb begin
        addr_d = I_ADDR;
        wdata_d = I_DATA;
    end

    // control register writes taken at the closing edge of the write
    always_comb begin
        brake_d = brake_q;
        mc_reset_d = mc_reset_q;
        irq_en_d = irq_en_q;
        led_d = led_q;
        if (wr_hit) begin
            if (addr_q[2:0] == OFS_MOTOR_BRAKE) begin
                brake_d = wdata_q[1:0];
            end else if (addr_q[2:0] == OFS_CHIP_HARD_RESET) begin
                mc_reset_d = wdata_q[1:0];
            end else if (addr_q[2:0] == OFS_IRQ_ENABLE_CAUSE) begin
                irq_en_d = wdata_q[BIT_IRQ_EN];
                led_d = wdata_q[BIT_LED];
            end
        end
    end

    // request follows the latched causes, so only a clear read at offset 7 or clearing the enable at offset 6 can drop it
    always_comb begin
        irq_d = irq_en_d && (|cause);
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            addr_q <= RST_ADDR;
            wdata_q <= RST_DATA;
            rdata_q <= RST_DATA;
            brake_q <= RST_BRAKE;
            mc_reset_q <= RST_CHIP_RESET;
            irq_en_q <= RST_IRQ_EN;
            led_q <= RST_LED;
            irq_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            brake_q <= brake_d;
            mc_reset_q <= mc_reset_d;
            irq_en_q <= irq_en_d;
            led_q <= led_d;
            irq_q <= irq_d;
        end
    end

    // motion chip strobes follow the host strobes with no queueing, so a
    // second command reaches the chip at once and cuts off the first
    always_comb begin
        O_MC_CS_B = 2'b11;
        if (cur_hit && (!I_IOR_B || !I_IOW_B)) begin
            if (cur_ofs == OFS_AX1_STATUS_CMD
                || cur_ofs == OFS_AX1_DATA) begin
                O_MC_CS_B[BIT_CH1] = 1'b0;
            end else if (cur_ofs == OFS_AX2_STATUS_CMD
                         || cur_ofs == OFS_AX2_DATA) begin
                O_MC_CS_B[BIT_CH2] = 1'b0;
            end
        end
    end

    assign O_MC_PS_B = cur_ofs[0];
    assign O_MC_RD_B = I_IOR_B;
    assign O_MC_WR_B = I_IOW_B;
    assign O_MC_WDATA = wdata_q;
    assign O_DATA = rdata_q;
    assign O_DATA_OE_B = ~(!I_IOR_B && cur_hit);
    assign O_BRAKE = brake_q;
    assign O_MC_RESET = mc_reset_q;
    assign O_FAULT_LED = led_q;
    assign O_IRQ = irq_q;

    // clear read with every source low in the same cycle
    sequence s_ack_read;
        ack_read && irq_src == 4'h0;
    endsequence

    // the request lags the cleared causes by one clock
    sequence s_irq_dropped;
        ##1 !O_IRQ;
    endsequence

    chk_decode_range: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        !port_hit(I_ADDR, I_BASE) |-> O_DATA_OE_B && O_MC_CS_B == 2'b11)
        else $error("access outside the port window was answered");

    chk_ch1_select: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        cur_hit && !I_IOW_B && cur_ofs == OFS_AX1_STATUS_CMD
        |-> O_MC_CS_B == 2'b10 && !O_MC_PS_B && !O_MC_WR_B)
        else $error("command write did not select channel one");

    chk_ch1_data_read: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        !I_IOR_B && cur_hit && cur_ofs == OFS_AX1_DATA
        |=> O_DATA == $past(I_MC1_RDATA))
        else $error("channel one data byte not returned");

    chk_ch2_select: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        cur_hit && !I_IOR_B && cur_ofs == OFS_AX2_DATA
        |-> O_MC_CS_B == 2'b01 && O_MC_PS_B)
        else $error("data access did not select channel two");

    chk_brake_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        wr_hit && addr_q[2:0] == OFS_MOTOR_BRAKE
        |=> O_BRAKE == $past(wdata_q[1:0]) ##1 $stable(O_BRAKE) || wr_end)
        else $error("brake bits not taken from the write");

    chk_reset_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        !(wr_hit && addr_q[2:0] == OFS_CHIP_HARD_RESET)
        |=> $stable(O_MC_RESET))
        else $error("chip reset bits changed without a write");

    chk_led_enable: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        wr_hit && addr_q[2:0] == OFS_IRQ_ENABLE_CAUSE
        |=> O_FAULT_LED == $past(wdata_q[0]) && irq_en_q == $past(wdata_q[1]))
        else $error("enable or lamp bit not taken from the write");

    chk_irq_gate: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        O_IRQ |-> irq_en_q && $past(|cause))
        else $error("request raised without enable or cause");

    chk_irq_hold: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        O_IRQ && !ack_read && !$past(ack_read) && irq_en_q && !wr_hit
        |=> O_IRQ)
        else $error("request dropped without a clear read");

    chk_ack_clears: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        s_ack_read |=> s_irq_dropped)
        else $error("clear read did not drop the request");

    chk_cause_read: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        !I_IOR_B && cur_hit && cur_ofs == OFS_IRQ_ENABLE_CAUSE
        |=> O_DATA[7:4] == 4'h0
        && O_DATA[3:0] == $past(cause | irq_src)
        && ($past(cause) & ~cause) == 4'h0
        && (cause & ~($past(cause) | $past(irq_src))) == 4'h0)
        else $error("cause read wrong or disturbed the causes");

    chk_ch2_command: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        cur_hit && !I_IOW_B && cur_ofs == OFS_AX2_STATUS_CMD
        |-> O_MC_CS_B == 2'h1 && !O_MC_PS_B && !O_MC_WR_B)
        else $error("command write did not select channel two");

    chk_ch1_status: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        !I_IOR_B && cur_hit && cur_ofs == OFS_AX1_STATUS_CMD
        |=> O_DATA == $past(I_MC1_RDATA))
        else $error("channel one status byte not returned");

    chk_ch2_data_read: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        !I_IOR_B && cur_hit && cur_ofs == OFS_AX2_DATA
        |=> O_DATA == $past(I_MC2_RDATA))
        else $error("channel two data byte not returned");

    chk_noop_read: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        !I_IOR_B && cur_hit
        && (cur_ofs == OFS_MOTOR_BRAKE || cur_ofs == OFS_CHIP_HARD_RESET)
        |=> O_DATA == RST_DATA)
        else $error("read of a write-only port returned data");

    chk_ack_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RST_B)
        wr_hit && addr_q[2:0] == OFS_IRQ_ACK
        |=> $stable(O_BRAKE) && $stable(O_MC_RESET)
        && $stable(O_FAULT_LED) && $stable(irq_en_q))
        else $error("write to the clear port changed a control");
endmodule : dsg_host_glue

// file: dv/dsg_mc_model.sv
// behavioural pair of motion chips on the card's chip bus
`timescale 1ns/1ps
module dsg_mc_model
    import dsg_pkg::*;
(
    // chip bus from the card
    input wire logic i_clk,
    input wire logic [1:0] i_cs_b,
    input wire logic i_ps_b,
    input wire logic i_rd_b,
    input wire logic i_wr_b,
    input wire logic [DATA_W-1:0] i_wdata,
    // interrupt requests commanded by the bench
    input wire logic [1:0] i_irq_req,
    // read data and interrupt lines
    output logic [DATA_W-1:0] o_rdata1,
    output logic [DATA_W-1:0] o_rdata2,
    output logic [1:0] o_irq
);
    logic [DATA_W-1:0] cmd_q [2];
    logic [DATA_W-1:0] data_q [2];
    logic [DATA_W-1:0] val [2];
    logic [1:0] seq_q;
    initial begin
        seq_q = 2'h0;
        cmd_q = '{8'h00, 8'h00};
        data_q = '{8'h00, 8'h00};
    end
    // flag shows in status whatever the host mask
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            val[k] = i_ps_b ? data_q[k]
                            : {4'h0, seq_q[k], 2'h0, i_irq_req[k]};
        end
    end
    // a released bus shows the inverse, so stale bytes cannot pass
    assign o_rdata1 = (!i_cs_b[0] && !i_rd_b) ? val[0] : ~val[0];
    assign o_rdata2 = (!i_cs_b[1] && !i_rd_b) ? val[1] : ~val[1];
    assign o_irq = i_irq_req;
    // a new command restarts the sequence, dropping one in progress
    always @(posedge i_clk) begin
        for (int k = 0; k < 2; k++) begin
            if (!i_cs_b[k] && !i_wr_b) begin
                if (i_ps_b) data_q[k] <= i_wdata;
                else begin
                    cmd_q[k] <= i_wdata;
                    seq_q[k] <= 1'b1;
                end
            end
        end
    end
endmodule : dsg_mc_model

// file: dv/tb_dsg_host_glue.sv
// self-checking bench for the host i/o glue
`timescale 1ns/1ps
module tb_dsg_host_glue;
    import dsg_pkg::*;
    logic clk, rst_b, ior_b, iow_b, oe_b, ps_b, rd_b, wr_b, led, irq;
    logic [ADDR_W-1:0] addr;
    logic [BASE_W-1:0] base;
    logic [DATA_W-1:0] wdat, odat, mc1, mc2, mwdat, d;
    logic [1:0] cs_b, brake, mrst, mc_irq, mc_req, heat;
    int mismatches, samples_checked;
    logic [DATA_W-1:0] exp_q [$];

    dsg_host_glue dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_BASE(base), .I_IOR_B(ior_b), .I_IOW_B(iow_b), .I_DATA(wdat),
        .O_DATA(odat), .O_DATA_OE_B(oe_b), .O_MC_CS_B(cs_b),
        .O_MC_PS_B(ps_b), .O_MC_RD_B(rd_b), .O_MC_WR_B(wr_b),
        .O_MC_WDATA(mwdat), .I_MC1_RDATA(mc1), .I_MC2_RDATA(mc2),
        .I_MC_IRQ(mc_irq), .I_OVERHEAT(heat), .O_BRAKE(brake),
        .O_MC_RESET(mrst), .O_FAULT_LED(led), .O_IRQ(irq));
    dsg_mc_model mc (.i_clk(clk), .i_cs_b(cs_b), .i_ps_b(ps_b),
        .i_rd_b(rd_b), .i_wr_b(wr_b), .i_wdata(mwdat), .i_irq_req(mc_req),
        .o_rdata1(mc1), .o_rdata2(mc2), .o_irq(mc_irq));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task check(input string nm, input logic [DATA_W-1:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // strobe two clocks low, address held one clock past the end edge
    task access(input logic wr, input logic [ADDR_W-1:0] a,
                input logic [DATA_W-1:0] dv);
        logic hit;
        hit = (a[ADDR_W-1:3] === base);
        step(1);
        addr = a;
        wdat = dv;
        if (wr) iow_b = 1'b0;
        else ior_b = 1'b0;
        step(1);
        check("oe_b", {7'h0, oe_b}, {7'h0, wr | !hit});
        if (hit && !a[2]) begin
            check("cs_b", {6'h0, cs_b}, a[1] ? 8'h01 : 8'h02);
            check("ps_b", {7'h0, ps_b}, {7'h0, a[0]});
        end else check("cs_b", {6'h0, cs_b}, 8'h03);
        step(1);
        iow_b = 1'b1;
        ior_b = 1'b1;
        // return just past the edge so callers never race the sampling
        step(1);
    endtask : access

    task wr(input int ofs, input logic [DATA_W-1:0] dv);
        access(1'b1, {base, 3'(ofs)}, dv);
    endtask : wr

    task rd(input int ofs, input logic [DATA_W-1:0] ev);
        if (ofs != 7) exp_q.push_back(ev);
        access(1'b0, {base, 3'(ofs)}, 8'h00);
    endtask : rd

    task ctl(input logic [1:0] eb, er, input logic el, ei);
        check("brake", {6'h0, brake}, {6'h0, eb});
        check("chip_reset", {6'h0, mrst}, {6'h0, er});
        check("led", {7'h0, led}, {7'h0, el});
        check("irq", {7'h0, irq}, {7'h0, ei});
    endtask : ctl

    // read data is settled at the strobe's release
    always @(posedge ior_b) begin
        if (exp_q.size() > 0) begin
            check("rdata", odat, exp_q.pop_front());
        end
    end

    initial begin
        #2_000_000;
        mismatches++;
        $display("timeout");
        close_out();
    end

    initial begin
        void'($urandom(29));
        rst_b = 1'b0;
        ior_b = 1'b1;
        iow_b = 1'b1;
        addr = 10'h000;
        wdat = 8'h00;
        mc_req = 2'h0;
        heat = 2'h0;
        base = 7'($urandom);
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        ctl(2'h0, 2'h0, 1'b0, 1'b0);
        // interrupts stay masked around command sequences
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr(k, d);
            check("chip_byte", k[0] ? mc.data_q[k/2] : mc.cmd_q[k/2],
                  d);
            rd(k, k[0] ? d : 8'h08);
        end
        d = 8'($urandom);
        wr(4, d);
        step(1);
        ctl(d[1:0], 2'h0, 1'b0, 1'b0);
        rd(4, 8'h00);
        wr(5, ~d);
        step(1);
        ctl(d[1:0], ~d[1:0], 1'b0, 1'b0);
        rd(5, 8'h00);
        wr(6, 8'h01);
        heat = 2'h1;
        step(2);
        ctl(d[1:0], ~d[1:0], 1'b1, 1'b0);
        heat = 2'h0;
        rd(6, 8'h01);
        rd(6, 8'h01);
        wr(6, 8'h02);
        step(1);
        ctl(d[1:0], ~d[1:0], 1'b0, 1'b1);
        wr(7, 8'hff);
        step(1);
        check("irq", {7'h0, irq}, 8'h01);
        rd(7, 8'h00);
        step(1);
        check("irq", {7'h0, irq}, 8'h00);
        rd(6, 8'h00);
        for (int k = 0; k < 4; k++) begin
            {mc_req, heat} = 4'(1 << k);
            step(2);
            check("irq", {7'h0, irq}, 8'h01);
            rd(6, 8'(1 << k));
            // after a chip interrupt the host decodes its status
            if (k >= 2) rd(k == 2 ? 0 : 2, 8'h09);
            {mc_req, heat} = 4'h0;
            rd(7, 8'h00);
            step(1);
            check("irq", {7'h0, irq}, 8'h00);
            rd(6, 8'h00);
        end
        access(1'b1, {base + 7'h1, 3'h4}, ~d);
        access(1'b0, {base + 7'h1, 3'h0}, 8'h00);
        step(1);
        ctl(d[1:0], ~d[1:0], 1'b0, 1'b0);
        wr(6, 8'h03);
        heat = 2'h2;
        step(2);
        ctl(d[1:0], ~d[1:0], 1'b1, 1'b1);
        rst_b = 1'b0;
        #1;
        ctl(2'h0, 2'h0, 1'b0, 1'b0);
        heat = 2'h0;
        step(1);
        rst_b = 1'b1;
        step(2);
        ctl(2'h0, 2'h0, 1'b0, 1'b0);
        check("pending", 8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule : tb_dsg_host_glue
